/* File: rtl/pin_sync.sv */
// two-flop synchroniser for a group of asynchronous inputs
// assumes each bit is an independent level
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* File: rtl/pol_protection_sequencer.sv */
// protection, sequencing and power-good supervisor with an APB register slave
// assumes analog comparators arrive asynchronous and the sync/data line is the timebase
// How it works
// - overcurrent threshold eleven steps, 132% after reset
// - trips retry every 130 ms unless latching
// - overvoltage threshold 110..130%, default 130%
// - ov/uv/ot/tracking trip after about 6 us
// - sequenced shutdown applies off delay and slew
// - critical shutdown turns both switches off
// - catastrophic shutdown turns low side on
// - overvoltage uses emergency or critical style
// - undervoltage threshold 75..90%, default 75%
// - uv and ot sequenced or critical style
// - ot trips at 120, restarts at 110
// - ot clears only after warning flag drops
// - temperature warning always active, in status
// - tracking trip only during ramp up, enabled
// - power-good high inside window, selectable limits
// - power-good on delay 0/10/50/150 ms
// - power-good drops at once or after delay
// - on delay 0..255 ms, off 0..63 ms
// - millisecond delays and retry counted from sync/data edges, trip delays from pclk
// - eight on and off slew settings
// - phase offset in sixteen 22.5 degree steps
// - sync/data pin is the shared pulled-up wire
// - fault line open-drain, any member pulls low
// - power-good pin level mirrored into status
// - five pulled-up address straps, floating reads one
`timescale 1ns/1ns
module pol_protection_sequencer
    import pol_seq_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sync_data_line_in,
    output logic             sync_data_line_out,
    output logic             sync_data_line_oe,
    input  wire logic        fault_line_in,
    output logic             fault_line_out,
    output logic             fault_line_oe,
    input  wire logic        power_good_output_in,
    output logic             power_good_output_out,
    output logic             power_good_output_oe,
    input  wire logic [4:0]  address_straps,
    input  wire logic        oc_cmp,
    input  wire logic        ov_cmp,
    input  wire logic        uv_cmp,
    input  wire logic        temp_hot_cmp,
    input  wire logic        temp_restart_cmp,
    input  wire logic        track_err_cmp,
    input  wire logic        vout_in_window,
    input  wire logic        ramp_done,
    output logic             high_side_enable,
    output logic             low_side_enable,
    output logic             ramp_up_cmd,
    output logic             ramp_down_cmd,
    output logic [3:0]       oc_thr_sel,
    output logic [1:0]       ov_thr_sel,
    output logic [1:0]       uv_thr_sel,
    output logic             pg_low_95,
    output logic             pg_high_105,
    output logic [2:0]       slew_on_sel,
    output logic [2:0]       slew_off_sel,
    output logic [3:0]       phase_sel
);
    localparam int NSYNC = 16;

    logic [NSYNC-1:0]  sync_q;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [PROT_W-1:0] prot_reg;
    logic [TIM_W-1:0]  tim_reg;
    logic [NFLT-1:0]   fault_cause;
    logic [4:0]        strap_addr;
    logic [1:0]        strap_wait;
    logic              sd_prev;
    logic [9:0]        edge_cnt;
    logic              ms_tick;
    logic [TRIP_CNT_W-1:0] q_cnt [4];
    logic [3:0]        slow_q;
    logic              ot_hold;
    seq_state_t        state;
    seq_state_t        next_state;
    logic [7:0]        dly_cnt;
    logic              shut_pend;
    logic              latch_req;
    logic              crowbar;
    logic              next_pend;
    logic              next_latch;
    logic              next_crowbar;
    logic              cnt_clr;
    logic [7:0]        pg_cnt;

    pin_sync #(.WIDTH(NSYNC)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({ramp_done, vout_in_window, track_err_cmp, temp_restart_cmp, temp_hot_cmp,
                    uv_cmp, ov_cmp, oc_cmp, address_straps, power_good_output_in,
                    fault_line_in, sync_data_line_in}),
        .sync_out (sync_q)
    );

    wire       sd_s      = sync_q[0];
    wire       ok_s      = sync_q[1];
    wire       pg_pin_s  = sync_q[2];
    wire [4:0] straps_s  = sync_q[7:3];
    wire       oc_s      = sync_q[8];
    wire       ov_s      = sync_q[9];
    wire       uv_s      = sync_q[10];
    wire       twarn_s   = sync_q[11];
    wire       tcool_s   = sync_q[12];
    wire       trk_s     = sync_q[13];
    wire       window_s  = sync_q[14];
    wire       rdone_s   = sync_q[15];

    wire       run       = ctrl_reg[CTRL_RUN];
    wire       pg_offd   = ctrl_reg[CTRL_PG_OFFD];
    wire [4:0] lat_en    = prot_reg[PROT_LAT_LSB +: NFLT];
    wire [7:0] on_dly    = tim_reg[TIM_ON_LSB +: 8];
    wire [7:0] off_dly   = {2'h0, tim_reg[TIM_OFF_LSB +: 6]};

    function automatic logic [7:0] pg_ms(input logic [1:0] sel);
        case (sel)
            2'h1:    pg_ms = 8'(PG_DLY_10_MS);
            2'h2:    pg_ms = 8'(PG_DLY_50_MS);
            2'h3:    pg_ms = 8'(PG_DLY_150_MS);
            default: pg_ms = 8'h00;
        endcase
    endfunction

    // bus decode; one wait state, write lands at the completing edge
    wire bus_req   = psel & penable & ~pready;
    wire bus_done  = psel & penable & pready & pwrite;
    wire hit_ctrl  = (paddr == CTRL_ADDR);
    wire hit_prot  = (paddr == PROT_ADDR);
    wire hit_tim   = (paddr == TIMING_ADDR);
    wire hit_stat  = (paddr == STATUS_ADDR);
    wire mapped    = hit_ctrl | hit_prot | hit_tim | hit_stat;
    wire [31:0] status_word = {11'h000, 8'(state), strap_addr, fault_cause, ok_s, twarn_s, pg_pin_s};
    wire [31:0] read_mux =
        hit_ctrl ? {30'h0, ctrl_reg} :
        hit_prot ? {13'h0, prot_reg} :
        hit_tim  ? {4'h0, tim_reg}   :
        hit_stat ? status_word       : 32'h00000000;

    // out-of-range threshold codes are clamped to the top step
    wire [3:0] oc_wr = (pwdata[PROT_OC_LSB +: 4] > OC_THR_MAX) ? OC_THR_MAX : pwdata[PROT_OC_LSB +: 4];
    wire [1:0] ov_wr = (pwdata[PROT_OV_LSB +: 2] > OV_THR_MAX) ? OV_THR_MAX : pwdata[PROT_OV_LSB +: 2];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= bus_req;
            pslverr <= bus_req & ~mapped;
            prdata  <= (bus_req & ~pwrite) ? read_mux : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RST;
            prot_reg <= PROT_RST;
            tim_reg  <= TIM_RST;
        end
        else if (bus_done)
        begin
            if (hit_ctrl)
                ctrl_reg <= pwdata[CTRL_W-1:0];
            if (hit_prot)
                prot_reg <= {pwdata[PROT_W-1:PROT_UV_LSB], ov_wr, oc_wr};
            if (hit_tim)
                tim_reg <= pwdata[TIM_W-1:0];
        end
    end

    // straps read after the synchroniser has filled; floating pins read one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_wait <= 2'h0;
            strap_addr <= 5'h00;
        end
        else if (strap_wait != 2'h3)
        begin
            strap_wait <= strap_wait + 2'h1;
            strap_addr <= straps_s;
        end
    end

    // millisecond tick from line falling edges, so timing tracks the manager's clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sd_prev  <= 1'b0; // no false edge
            edge_cnt <= 10'h000;
            ms_tick  <= 1'b0;
        end
        else
        begin
            sd_prev <= sd_s;
            ms_tick <= 1'b0;
            if (sd_prev & ~sd_s)
            begin
                if (edge_cnt == 10'(SD_EDGES_PER_MS - 1))
                begin
                    edge_cnt <= 10'h000;
                    ms_tick  <= 1'b1;
                end
                else
                    edge_cnt <= edge_cnt + 10'h001;
            end
        end
    end

    // slow faults must persist for the trip delay
    wire output_on = (state == ST_RAMP_UP) | (state == ST_ON) | (state == ST_OFF_DLY) | (state == ST_RAMP_DN);
    wire [3:0] slow_raw = {trk_s & prot_reg[PROT_TRK_EN] & (state == ST_RAMP_UP),
                           twarn_s, uv_s & (state == ST_ON), ov_s};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_qual
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    q_cnt[gi] <= '0;
                else if (!slow_raw[gi])
                    q_cnt[gi] <= '0;
                else if (q_cnt[gi] != TRIP_CNT_MAX)
                    q_cnt[gi] <= q_cnt[gi] + TRIP_CNT_W'(1);
            end
            assign slow_q[gi] = (q_cnt[gi] == TRIP_CNT_MAX);
        end
    endgenerate

    // overtemperature stays held until warning drops and restart temperature is reached
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ot_hold <= 1'b0;
        else if (slow_q[2])
            ot_hold <= 1'b1;
        else if (!twarn_s && tcool_s)
            ot_hold <= 1'b0;
    end

    wire [NFLT-1:0] fault_now = {slow_q[3], slow_q[2], slow_q[1], slow_q[0], oc_s} & {NFLT{output_on}};
    wire trip       = |fault_now;
    wire trip_latch = |(fault_now & lat_en);
    wire trip_emer  = fault_now[F_OV] & ~prot_reg[PROT_OV_CRIT];
    wire trip_crit  = fault_now[F_OC] | (fault_now[F_OV] & prot_reg[PROT_OV_CRIT]) |
                      (fault_now[F_UV] & prot_reg[PROT_UV_CRIT]) | (fault_now[F_OT] & prot_reg[PROT_OT_CRIT]);
    wire trip_hard  = trip_emer | trip_crit;
    wire hold_fault = oc_s | ov_s | ot_hold;

    always_comb
    begin
        next_state   = state;
        next_pend    = shut_pend;
        next_latch   = latch_req;
        next_crowbar = crowbar;
        cnt_clr      = 1'b0;
        case (state)
            ST_OFF:
            begin
                next_pend    = 1'b0;
                next_latch   = 1'b0;
                next_crowbar = 1'b0;
                if (run)
                    next_state = ST_ON_DLY;
            end
            ST_ON_DLY:
            begin
                if (!run)
                    next_state = ST_OFF;
                else if (dly_cnt >= on_dly)
                    next_state = ST_RAMP_UP;
            end
            ST_RAMP_UP, ST_ON, ST_OFF_DLY, ST_RAMP_DN:
            begin
                if (trip)
                begin
                    next_pend  = 1'b1;
                    next_latch = latch_req | trip_latch;
                end
                if (trip_hard)
                begin
                    next_state   = next_latch ? ST_LATCHED : ST_RETRY;
                    next_crowbar = trip_emer;
                end
                else if (state == ST_OFF_DLY)
                begin
                    if (dly_cnt >= off_dly)
                        next_state = ST_RAMP_DN;
                end
                else if (state == ST_RAMP_DN)
                begin
                    if (rdone_s)
                        next_state = !next_pend ? ST_OFF : (next_latch ? ST_LATCHED : ST_RETRY);
                end
                else if (trip || !run)
                    next_state = ST_OFF_DLY;
                else if (state == ST_RAMP_UP && rdone_s)
                    next_state = ST_ON;
            end
            ST_RETRY:
            begin
                if (!run)
                    next_state = ST_OFF;
                else if (dly_cnt >= 8'(RETRY_MS))
                begin
                    if (hold_fault)
                        cnt_clr = 1'b1;
                    else
                    begin
                        next_state   = ST_ON_DLY;
                        next_pend    = 1'b0;
                        next_latch   = 1'b0;
                        next_crowbar = 1'b0;
                    end
                end
            end
            ST_LATCHED:
            begin
                if (!run)
                    next_state = ST_OFF;
            end
            default:
                next_state = ST_OFF;
        endcase
    end

    wire next_on = (next_state == ST_RAMP_UP) | (next_state == ST_ON) |
                   (next_state == ST_OFF_DLY) | (next_state == ST_RAMP_DN);
    wire sticky_clr_ok = bus_done & hit_stat;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state            <= ST_OFF;
            dly_cnt          <= 8'h00;
            shut_pend        <= 1'b0;
            latch_req        <= 1'b0;
            crowbar          <= 1'b0;
            high_side_enable <= 1'b0;
            low_side_enable  <= 1'b0;
            ramp_up_cmd      <= 1'b0;
            ramp_down_cmd    <= 1'b0;
            fault_line_oe    <= 1'b0;
            fault_cause      <= '0;
        end
        else
        begin
            state     <= next_state;
            shut_pend <= next_pend;
            latch_req <= next_latch;
            crowbar   <= next_crowbar;
            if (next_state != state || cnt_clr)
                dly_cnt <= 8'h00;
            else if (ms_tick && dly_cnt != 8'hFF)
                dly_cnt <= dly_cnt + 8'h01;
            high_side_enable <= next_on;
            low_side_enable  <= next_on | next_crowbar;
            ramp_up_cmd      <= (next_state == ST_RAMP_UP);
            ramp_down_cmd    <= (next_state == ST_RAMP_DN);
            fault_line_oe    <= next_pend | (next_state == ST_RETRY) | (next_state == ST_LATCHED);
            // new causes win over a write-one clear
            fault_cause <= (sticky_clr_ok ? (fault_cause & ~pwdata[ST_FLT_LSB +: NFLT]) : fault_cause) | fault_now;
        end
    end

    // power good, open drain: the low drive is the stored state
    wire pg_level  = ~power_good_output_oe;
    wire pg_target = (state == ST_ON) & window_s;
    wire [7:0] pg_need = pg_target ? pg_ms(tim_reg[TIM_PGON_LSB +: 2]) : pg_ms(tim_reg[TIM_PGOF_LSB +: 2]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_good_output_oe <= 1'b1;
            pg_cnt               <= 8'h00;
        end
        else if (pg_target == pg_level)
            pg_cnt <= 8'h00;
        else if (!pg_target && !pg_offd)
            power_good_output_oe <= 1'b1;
        else if (pg_cnt >= pg_need)
        begin
            power_good_output_oe <= ~pg_target;
            pg_cnt               <= 8'h00;
        end
        else if (ms_tick)
            pg_cnt <= pg_cnt + 8'h01;
    end

    // the line is only received here; the pins are never driven high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_data_line_out    <= 1'b0;
            sync_data_line_oe     <= 1'b0;
            fault_line_out        <= 1'b0;
            power_good_output_out <= 1'b0;
        end
    end

    assign oc_thr_sel   = prot_reg[PROT_OC_LSB +: 4];
    assign ov_thr_sel   = prot_reg[PROT_OV_LSB +: 2];
    assign uv_thr_sel   = prot_reg[PROT_UV_LSB +: 2];
    assign pg_low_95    = prot_reg[PROT_PG_LO95];
    assign pg_high_105  = prot_reg[PROT_PG_HI105];
    assign slew_on_sel  = tim_reg[TIM_SLON_LSB +: 3];
    assign slew_off_sel = tim_reg[TIM_SLOF_LSB +: 3];
    assign phase_sel    = tim_reg[TIM_PH_LSB +: 4];

endmodule

/* File: rtl/pol_seq_pkg.sv */
// constants, register map and state codes for the point-of-load protection sequencer
// assumes a 125 MHz APB clock and a sync/data line near 500 kHz
package pol_seq_pkg;

    localparam int CLK_PERIOD_NS   = 8;
    localparam int TRIP_DELAY_NS   = 6000;
    localparam int TRIP_DELAY_CYC  = (TRIP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIP_CNT_W      = 10;
    localparam logic [TRIP_CNT_W-1:0] TRIP_CNT_MAX = TRIP_CNT_W'(TRIP_DELAY_CYC - 1);

    localparam int SD_FREQ_KHZ     = 500;
    localparam int SD_EDGES_PER_MS = SD_FREQ_KHZ;
    localparam int RETRY_MS        = 130;
    localparam int PG_DLY_10_MS    = 10;
    localparam int PG_DLY_50_MS    = 50;
    localparam int PG_DLY_150_MS   = 150;

    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] PROT_ADDR   = 12'h004;
    localparam logic [11:0] TIMING_ADDR = 12'h008;
    localparam logic [11:0] STATUS_ADDR = 12'h00C;

    // control: run, power-good off delay enable
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_PG_OFFD = 1;
    localparam int CTRL_W       = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

    // protection: thresholds, turn-off styles, latch enables, tracking, power-good window
    localparam int PROT_OC_LSB  = 0;
    localparam int PROT_OV_LSB  = 4;
    localparam int PROT_UV_LSB  = 6;
    localparam int PROT_OV_CRIT = 8;
    localparam int PROT_UV_CRIT = 9;
    localparam int PROT_OT_CRIT = 10;
    localparam int PROT_LAT_LSB = 11;
    localparam int PROT_TRK_EN  = 16;
    localparam int PROT_PG_LO95 = 17;
    localparam int PROT_PG_HI105 = 18;
    localparam int PROT_W       = 19;
    localparam logic [3:0] OC_THR_RST = 4'hA;
    localparam logic [1:0] OV_THR_RST = 2'h2;
    localparam logic [1:0] UV_THR_RST = 2'h0;
    localparam logic [PROT_W-1:0] PROT_RST = {11'h000, UV_THR_RST, OV_THR_RST, OC_THR_RST};
    localparam logic [3:0] OC_THR_MAX = 4'hA;
    localparam logic [1:0] OV_THR_MAX = 2'h2;

    // timing: delays, power-good delay selects, slews, phase
    localparam int TIM_ON_LSB   = 0;
    localparam int TIM_OFF_LSB  = 8;
    localparam int TIM_PGON_LSB = 14;
    localparam int TIM_PGOF_LSB = 16;
    localparam int TIM_SLON_LSB = 18;
    localparam int TIM_SLOF_LSB = 21;
    localparam int TIM_PH_LSB   = 24;
    localparam int TIM_W        = 28;
    localparam logic [TIM_W-1:0] TIM_RST = 28'h0000000;

    // status fields
    localparam int ST_PG     = 0;
    localparam int ST_TWARN  = 1;
    localparam int ST_OKLINE = 2;
    localparam int ST_FLT_LSB = 3;
    localparam int ST_ADR_LSB = 8;
    localparam int ST_STA_LSB = 13;

    // fault index order
    localparam int F_OC  = 0;
    localparam int F_OV  = 1;
    localparam int F_UV  = 2;
    localparam int F_OT  = 3;
    localparam int F_TRK = 4;
    localparam int NFLT  = 5;

    typedef enum logic [7:0] {
        ST_OFF     = 8'h01,
        ST_ON_DLY  = 8'h02,
        ST_RAMP_UP = 8'h04,
        ST_ON      = 8'h08,
        ST_OFF_DLY = 8'h10,
        ST_RAMP_DN = 8'h20,
        ST_RETRY   = 8'h40,
        ST_LATCHED = 8'h80
    } seq_state_t;

endpackage

/* File: testbench/pol_protection_sequencer_tb_top.sv */
// self-checking bench for the protection sequencer
// assumes the manager model owns the sync/data line and the pull-ups
`timescale 1ns/1ns
module pol_protection_sequencer_tb_top;
    import pol_seq_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frames_on = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sync_data_line_out, sync_data_line_oe, fault_line_out, fault_line_oe;
    logic power_good_output_out, power_good_output_oe, high_side_enable, low_side_enable;
    logic ramp_up_cmd, ramp_down_cmd, pg_low_95, pg_high_105, sync_data_line_in, fault_line_in;
    logic power_good_output_in, oc_cmp = 1'b0, ov_cmp = 1'b0, uv_cmp = 1'b0, temp_hot_cmp = 1'b0;
    logic temp_restart_cmp = 1'b1, track_err_cmp = 1'b0, vout_in_window = 1'b0, ramp_done = 1'b0;
    logic [4:0] address_straps = 5'h15;
    logic [3:0] oc_thr_sel, phase_sel;
    logic [1:0] ov_thr_sel, uv_thr_sel;
    logic [2:0] slew_on_sel, slew_off_sel;
    int miscompares = 0, compares = 0, cyc = 0, n, k, t0;
    always #4 pclk = !pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    pol_protection_sequencer u_pol_protection_sequencer (.*);
    power_manager_model u_power_manager_model (.frames_on, .sd_pull(sync_data_line_oe),
        .ok_pull(fault_line_oe), .pg_pull(power_good_output_oe), .sd_wire(sync_data_line_in),
        .ok_wire(fault_line_in), .pg_wire(power_good_output_in));
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic guard(input logic late);
        if (late)
        begin
            cmp("wait", 32'h0, 32'h1);
            wrap_up;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge pclk);
        guard(n == 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_st(input logic [7:0] s);
        apb(1'b0, STATUS_ADDR, 32'h0);
        for (k = 0; rd[20:13] !== s && k < 4000; k++)
            apb(1'b0, STATUS_ADDR, 32'h0);
        guard(k == 4000);
    endtask
    task automatic t_regs;
        apb(1'b0, PROT_ADDR, 32'h0);
        cmp("prot", 32'h2A, rd);
        apb(1'b0, STATUS_ADDR, 32'h0);
        cmp("straps", 32'h15, 32'(rd[12:8]));
        apb(1'b1, PROT_ADDR, 32'h000600FF);
        apb(1'b0, PROT_ADDR, 32'h0);
        cmp("prot", 32'h000600EA, rd);
        cmp("pins", 32'h2AF, 32'({oc_thr_sel, ov_thr_sel, pg_low_95, pg_high_105, uv_thr_sel}));
        apb(1'b0, TIMING_ADDR, 32'h0);
        cmp("timing", 32'h0, rd);
        apb(1'b1, TIMING_ADDR, 32'hFFFFFFFF);
        apb(1'b0, TIMING_ADDR, 32'h0);
        cmp("timing", 32'h0FFFFFFF, rd);
        cmp("slew", 32'h3FF, 32'({slew_on_sel, slew_off_sel, phase_sel}));
        apb(1'b0, 12'h010, 32'h0);
        cmp("unmapped", 32'h1, 32'(err));
        apb(1'b1, PROT_ADDR, 32'h0000002A);
        apb(1'b1, TIMING_ADDR, 32'h00000001);
        $display("regs done");
    endtask
    task automatic t_power_up;
        frames_on <= 1'b1;
        vout_in_window <= 1'b1;
        t0 = cyc;
        apb(1'b1, CTRL_ADDR, 32'h1);
        for (k = 0; ramp_up_cmd !== 1'b1 && k < 20000; k++)
            @(posedge pclk);
        guard(k == 20000);
        cmp("on delay", 32'h1, 32'(cyc - t0 > 7600 && cyc - t0 < 8000));
        ramp_done <= 1'b1;
        wait_st(8'h08);
        repeat (8) @(posedge pclk);
        apb(1'b0, STATUS_ADDR, 32'h0);
        cmp("pg", 32'h1, 32'(rd[0]));
        $display("power up done");
    endtask
    task automatic t_ov;
        ov_cmp <= 1'b1;
        repeat (600) @(posedge pclk);
        ov_cmp <= 1'b0;
        @(posedge pclk);
        cmp("short ov", 32'h1, 32'(high_side_enable));
        ov_cmp <= 1'b1;
        repeat (800) @(posedge pclk);
        cmp("ov off", 32'h3, 32'({high_side_enable, low_side_enable, fault_line_oe}));
        ov_cmp <= 1'b0;
        apb(1'b0, STATUS_ADDR, 32'h0);
        cmp("cause", 32'h2, 32'(rd[7:3]));
        cmp("retry", 32'h40, 32'(rd[20:13]));
        cmp("pg drop", 32'h1, 32'(power_good_output_oe));
        $display("ov done");
    endtask
    task automatic rst;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic t_latch;
        rst;
        apb(1'b1, PROT_ADDR, 32'h0000082A);
        apb(1'b1, CTRL_ADDR, 32'h1);
        wait_st(8'h08);
        oc_cmp <= 1'b1;
        repeat (6) @(posedge pclk);
        cmp("oc off", 32'h0, 32'({high_side_enable, low_side_enable}));
        oc_cmp <= 1'b0;
        temp_hot_cmp <= 1'b1;
        repeat (200) @(posedge pclk);
        apb(1'b0, STATUS_ADDR, 32'h0);
        cmp("latched", 32'h80, 32'(rd[20:13]));
        cmp("warn", 32'h1, 32'(rd[1]));
        temp_hot_cmp <= 1'b0;
        apb(1'b1, CTRL_ADDR, 32'h0);
        wait_st(8'h01);
        apb(1'b1, CTRL_ADDR, 32'h1);
        wait_st(8'h08);
        $display("latch done");
    endtask
    initial
    begin
        rst;
        t_regs;
        t_power_up;
        t_ov;
        t_latch;
        wrap_up;
    end
endmodule

/* File: testbench/pol_seq_properties.sv */
// port assertions for the protection sequencer
// assumes it is bound into every sequencer instance
`timescale 1ns/1ns
module pol_seq_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        oc_cmp,
    input wire logic        ov_cmp,
    input wire logic        vout_in_window,
    input wire logic        high_side_enable,
    input wire logic        low_side_enable,
    input wire logic        sync_data_line_oe,
    input wire logic        fault_line_out,
    input wire logic        power_good_output_out,
    input wire logic        power_good_output_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] ov_run;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) ov_run <= 10'h000;
        else if (!ov_cmp) ov_run <= 10'h000;
        else if (ov_run != 10'h3FF) ov_run <= ov_run + 10'h001;
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("late pready");
    apb_pulse_a: assert property (pready |=> !pready) else $error("long pready");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray prdata");
    oc_critical_a: assert property (oc_cmp [*5] |=> !high_side_enable && !low_side_enable)
        else $error("oc not off");
    ov_trip_a: assert property (ov_run == 10'h30C |-> !high_side_enable) else $error("ov not off");
    open_drain_a: assert property (!sync_data_line_oe && !fault_line_out && !power_good_output_out)
        else $error("pin driven high");
    pg_window_a: assert property ($fell(power_good_output_oe) |-> $past(vout_in_window, 3))
        else $error("pg outside window");
    cover property (pready && pslverr);
    cover property ($fell(high_side_enable));
    cover property ($fell(power_good_output_oe));
endmodule
bind pol_protection_sequencer pol_seq_properties u_pol_seq_properties (.*);

/* File: testbench/power_manager_model.sv */
// manager side: sync/data line source and pulled-up shared wires
// assumes the device only pulls wires low through its enables
`timescale 1ns/1ns
module power_manager_model (
    input  wire logic frames_on,
    input  wire logic sd_pull,
    input  wire logic ok_pull,
    input  wire logic pg_pull,
    output logic      sd_wire,
    output logic      ok_wire,
    output logic      pg_wire
);
    logic mgr_low = 1'b0;
    // 125 ns cycle, 25% sync pulse; line rests high between frames
    always
    begin
        if (frames_on)
        begin
            mgr_low = 1'b1;
            #31;
            mgr_low = 1'b0;
            #94;
        end
        else
            #125;
    end
    assign sd_wire = !(mgr_low || sd_pull);
    assign ok_wire = !ok_pull;
    assign pg_wire = !pg_pull;
endmodule
